//--- core/phy_mgmt_pkg.sv
package phy_mgmt_pkg;

  // transceiver addressing after reset
  localparam logic [4:0] PORT1_DEFAULT_ADDRESS = 5'h01;
  localparam logic [4:0] PORT2_DEFAULT_ADDRESS = 5'h02;
  localparam logic [4:0] PORT2_ADDRESS_STEP = 5'h01;

  // management register indices
  localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
  localparam logic [4:0] IDX_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] IDX_IDENTIFIER_LOW = 5'h03;
  localparam logic [4:0] IDX_NEGOTIATION_ADVERTISE = 5'h04;
  localparam logic [4:0] IDX_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] IDX_CABLE_DIAG = 5'h1d;
  localparam logic [4:0] IDX_SPECIAL = 5'h1f;

  // switch-side register offsets, port 2 sits one stride above port 1
  localparam logic [7:0] SW_GLOBAL_ADDRESS_OFFSET = 8'h0f;
  localparam logic [7:0] SW_PORT_CTRL_A_OFFSET = 8'h1c;
  localparam logic [7:0] SW_PORT_CTRL_B_OFFSET = 8'h1d;
  localparam logic [7:0] SW_PORT_CTRL_C_OFFSET = 8'h1f;
  localparam logic [7:0] SW_PORT_STRIDE = 8'h10;

  // switch register reset values
  localparam logic [7:0] SW_GLOBAL_ADDRESS_RESET = 8'h08;
  localparam logic [7:0] SW_PORT_CTRL_A_RESET = 8'h9f;
  localparam logic [7:0] SW_PORT_CTRL_B_RESET = 8'h00;
  localparam logic [7:0] SW_PORT_CTRL_C_RESET = 8'h80;

  // fields of the switch control bytes
  localparam int ADDR_FIELD_LSB = 3;
  localparam int A_AN_ENABLE = 7;
  localparam int A_FORCE_100 = 6;
  localparam int A_FULL_DUPLEX = 5;
  localparam int B_INDICATOR_DISABLE = 7;
  localparam int B_TRANSMIT_DISABLE = 6;
  localparam int B_RESTART_AN = 5;
  localparam int B_FAULT_DISABLE = 4;
  localparam int B_POWER_DOWN = 3;
  localparam int B_CROSSOVER_DISABLE = 2;
  localparam int B_FORCE_STRAIGHT = 1;
  localparam int B_LOOPBACK = 0;
  localparam int C_CROSSOVER_VARIANT = 7;

  // fields of the basic control word
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_FORCE_100 = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_RESTART_AN = 9;
  localparam int CTL_FULL_DUPLEX = 8;
  localparam int CTL_CROSSOVER_VARIANT = 5;
  localparam int CTL_FORCE_STRAIGHT = 4;
  localparam int CTL_CROSSOVER_DISABLE = 3;
  localparam int CTL_FAULT_DISABLE = 2;
  localparam int CTL_TRANSMIT_DISABLE = 1;
  localparam int CTL_INDICATOR_DISABLE = 0;

  // fixed status and advertise content, reset values of the diagnostic words
  localparam logic [3:0] STATUS_ABILITY = 4'hf;
  localparam logic [4:0] ADVERTISE_SELECTOR = 5'h01;
  localparam logic [15:0] CABLE_DIAG_RESET = 16'h0000;
  localparam logic [15:0] SPECIAL_RESET = 16'h0000;

  // management frame layout
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [4:0] HEADER_LAST = 5'h0c;
  localparam logic [4:0] READ_LAST = 5'h11;
  localparam logic [4:0] WRITE_LAST = 5'h11;

endpackage

//--- core/mgmt_if.sv
`timescale 1ns/100ps
interface mgmt_if;
  logic req;
  logic wr;
  logic [4:0] phy_addr;
  logic [4:0] reg_index;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic hit;

  modport frame_side (output req, wr, phy_addr, reg_index, wdata, input rdata, hit);
  modport reg_side (input req, wr, phy_addr, reg_index, wdata, output rdata, hit);
endinterface

//--- core/mdio_serial.sv
`timescale 1ns/100ps
module mdio_serial
  import phy_mgmt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // decoded transactions
  mgmt_if.frame_side bus
);

  typedef enum logic [1:0] {st_idle, st_header, st_read, st_write} state_type;

  state_type state;
  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic [5:0] ones;
  logic [4:0] count;
  logic [15:0] shift;
  logic [15:0] out_shift;

  // pins cross into the clock domain through two flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1 <= mdc_in;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
    end
  end

  // edge and header decode
  wire logic rise = mdc_s2 & ~mdc_s3;
  wire logic bit_in = mdio_s2;
  wire logic [12:0] header = {shift[11:0], bit_in};
  wire logic header_ok = header[12] & (header[11:10] == OP_READ || header[11:10] == OP_WRITE);

  // frame sequencer; the pin is updated just after the master's sampling edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= st_idle;
      ones <= 6'h00;
      count <= 5'h00;
      shift <= 16'h0000;
      out_shift <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe_out <= 1'b0;
      bus.req <= 1'b0;
      bus.wr <= 1'b0;
      bus.phy_addr <= 5'h00;
      bus.reg_index <= 5'h00;
      bus.wdata <= 16'h0000;
    end else begin
      bus.req <= 1'b0;
      if (rise) begin
        case (state)
          st_idle: begin
            count <= 5'h00;
            if (bit_in) begin
              if (ones != PREAMBLE_BITS) ones <= ones + 6'h01;
            end else begin
              ones <= 6'h00;
              if (ones == PREAMBLE_BITS) state <= st_header;
            end
          end
          st_header: begin
            shift <= {shift[14:0], bit_in};
            count <= count + 5'h01;
            if (count == HEADER_LAST) begin
              count <= 5'h00;
              bus.phy_addr <= header[9:5];
              bus.reg_index <= header[4:0];
              if (!header_ok) begin
                state <= st_idle;
              end else if (header[11:10] == OP_READ) begin
                bus.req <= 1'b1;
                bus.wr <= 1'b0;
                state <= st_read;
              end else begin
                state <= st_write;
              end
            end
          end
          st_read: begin
            count <= count + 5'h01;
            if (count == 5'h00) begin
              // only answer for our own addresses, others may share the wire
              mdio_oe_out <= bus.hit;
              mdio_out <= 1'b0;
              out_shift <= bus.rdata;
            end else if (count == READ_LAST) begin
              mdio_oe_out <= 1'b0;
              mdio_out <= 1'b1;
              state <= st_idle;
            end else begin
              mdio_out <= out_shift[15];
              out_shift <= {out_shift[14:0], 1'b0};
            end
          end
          st_write: begin
            shift <= {shift[14:0], bit_in};
            count <= count + 5'h01;
            if (count == WRITE_LAST) begin
              bus.req <= 1'b1;
              bus.wr <= 1'b1;
              bus.wdata <= {shift[14:0], bit_in};
              state <= st_idle;
            end
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

endmodule // mdio_serial

//--- core/phy_mgmt_regs.sv
`timescale 1ns/100ps
module phy_mgmt_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [15:0] IDENTIFIER_HIGH = 16'h1234, // arbitrary value
  parameter logic [15:0] IDENTIFIER_LOW = 16'h5678 // arbitrary value
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // switch configuration byte port
  input wire logic [7:0] sw_addr_in,
  input wire logic sw_wr_in,
  input wire logic [7:0] sw_wdata_in,
  output logic [7:0] sw_rdata_out,
  // per-port transceiver status
  input wire logic [1:0] link_up_in,
  input wire logic [1:0] an_done_in,
  input wire logic [1:0] far_fault_in,
  input wire logic [1:0][4:0] partner_ability_in,
  // per-port transceiver controls
  output logic [1:0] loopback_out,
  output logic [1:0] force_100_out,
  output logic [1:0] an_enable_out,
  output logic [1:0] power_down_out,
  output logic [1:0] restart_an_out,
  output logic [1:0] full_duplex_out,
  output logic [1:0] crossover_variant_select_out,
  output logic [1:0] force_straight_out,
  output logic [1:0] crossover_disable_out,
  output logic [1:0] fault_detect_disable_out,
  output logic [1:0] transmit_disable_out,
  output logic [1:0] indicator_disable_out,
  output logic [1:0] far_fault_out
);

  mgmt_if mif ();

  logic [7:0] global_addr;
  logic [7:0] ctrl_a [2];
  logic [7:0] ctrl_b [2];
  logic [7:0] ctrl_c [2];
  logic [15:0] cable_diag [2];
  logic [15:0] special [2];
  logic [15:0] read_word [2];
  logic [7:0] sw_word_a [2];
  logic [7:0] sw_word_b [2];
  logic [7:0] sw_word_c [2];
  logic [1:0] sel;

  // frame decoding on the management pins
  mdio_serial frame (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .mdc_in(mdc_in),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out),
    .bus(mif)
  );

  // one field moves both addresses so the pair never collides
  wire logic [4:0] port1_address = global_addr[7:ADDR_FIELD_LSB];
  wire logic [4:0] port2_address = 5'(port1_address + PORT2_ADDRESS_STEP);
  assign sel[0] = (mif.phy_addr == port1_address);
  assign sel[1] = (mif.phy_addr == port2_address);
  wire logic sel_any = |sel;
  wire logic [15:0] mii_read = sel[0] ? read_word[0] : (sel[1] ? read_word[1] : 16'h0000);
  wire logic idx_control = (mif.reg_index == IDX_BASIC_CONTROL);
  wire logic idx_advertise = (mif.reg_index == IDX_NEGOTIATION_ADVERTISE);
  wire logic sw_global_wr = sw_wr_in & (sw_addr_in == SW_GLOBAL_ADDRESS_OFFSET);

  // global address byte, switch side only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) global_addr <= SW_GLOBAL_ADDRESS_RESET;
    else if (sw_global_wr) global_addr <= sw_wdata_in;
  end

  // management read answer is captured one clock after the header
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mif.rdata <= 16'h0000;
      mif.hit <= 1'b0;
    end else if (mif.req && !mif.wr) begin
      mif.rdata <= mii_read;
      mif.hit <= sel_any;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      localparam logic [7:0] OFS = 8'(SW_PORT_STRIDE * p);
      wire logic mii_wr = mif.req & mif.wr & sel[p];
      wire logic wr_control = mii_wr & idx_control;
      wire logic wr_advertise = mii_wr & idx_advertise;
      wire logic wr_cable = mii_wr & (mif.reg_index == IDX_CABLE_DIAG);
      wire logic wr_special = mii_wr & (mif.reg_index == IDX_SPECIAL);
      wire logic sw_wr_a = sw_wr_in & (sw_addr_in == 8'(SW_PORT_CTRL_A_OFFSET + OFS));
      wire logic sw_wr_b = sw_wr_in & (sw_addr_in == 8'(SW_PORT_CTRL_B_OFFSET + OFS));
      wire logic sw_wr_c = sw_wr_in & (sw_addr_in == 8'(SW_PORT_CTRL_C_OFFSET + OFS));
      wire logic [15:0] wd = mif.wdata;
      wire logic fault_seen = far_fault_in[p] & ~ctrl_b[p][B_FAULT_DISABLE];

      // unsupported bits are constant zero, never stored
      wire logic [15:0] control_word = {1'b0, ctrl_b[p][B_LOOPBACK],
        ctrl_a[p][A_FORCE_100], ctrl_a[p][A_AN_ENABLE], ctrl_b[p][B_POWER_DOWN], 1'b0,
        ctrl_b[p][B_RESTART_AN], ctrl_a[p][A_FULL_DUPLEX], 2'b00,
        ctrl_c[p][C_CROSSOVER_VARIANT], ctrl_b[p][B_FORCE_STRAIGHT],
        ctrl_b[p][B_CROSSOVER_DISABLE], ctrl_b[p][B_FAULT_DISABLE],
        ctrl_b[p][B_TRANSMIT_DISABLE], ctrl_b[p][B_INDICATOR_DISABLE]};
      wire logic [15:0] status_word = {1'b0, STATUS_ABILITY, 4'h0, 1'b0, an_done_in[p],
        fault_seen, 1'b1, link_up_in[p], 2'b00};
      wire logic [15:0] advertise_word = {5'h00, ctrl_a[p][4], 1'b0, ctrl_a[p][3:0],
        ADVERTISE_SELECTOR};
      wire logic [15:0] partner_word = {5'h00, partner_ability_in[p][4], 1'b0,
        partner_ability_in[p][3:0], 5'h00};

      // index decode; holes fall through to zero
      assign read_word[p] =
        (mif.reg_index == IDX_BASIC_CONTROL) ? control_word :
        (mif.reg_index == IDX_BASIC_STATUS) ? status_word :
        (mif.reg_index == IDX_IDENTIFIER_HIGH) ? IDENTIFIER_HIGH :
        (mif.reg_index == IDX_IDENTIFIER_LOW) ? IDENTIFIER_LOW :
        (mif.reg_index == IDX_NEGOTIATION_ADVERTISE) ? advertise_word :
        (mif.reg_index == IDX_PARTNER_ABILITY) ? partner_word :
        (mif.reg_index == IDX_CABLE_DIAG) ? cable_diag[p] :
        (mif.reg_index == IDX_SPECIAL) ? special[p] : 16'h0000;

      // shared byte a: management path wins a same-cycle collision
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl_a[p] <= SW_PORT_CTRL_A_RESET;
        end else if (wr_control) begin
          ctrl_a[p][A_AN_ENABLE] <= wd[CTL_AN_ENABLE];
          ctrl_a[p][A_FORCE_100] <= wd[CTL_FORCE_100];
          ctrl_a[p][A_FULL_DUPLEX] <= wd[CTL_FULL_DUPLEX];
        end else if (wr_advertise) begin
          ctrl_a[p][4:0] <= {wd[10], wd[8:5]};
        end else if (sw_wr_a) begin
          ctrl_a[p] <= sw_wdata_in;
        end
      end

      // shared byte b holds loopback and the line options
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl_b[p] <= SW_PORT_CTRL_B_RESET;
        end else if (wr_control) begin
          ctrl_b[p] <= {wd[CTL_INDICATOR_DISABLE], wd[CTL_TRANSMIT_DISABLE],
            wd[CTL_RESTART_AN], wd[CTL_FAULT_DISABLE], wd[CTL_POWER_DOWN],
            wd[CTL_CROSSOVER_DISABLE], wd[CTL_FORCE_STRAIGHT],
            wd[CTL_LOOPBACK]};
        end else if (sw_wr_b) begin
          ctrl_b[p] <= sw_wdata_in;
        end
      end

      // shared byte c carries the crossover variant choice
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) ctrl_c[p] <= SW_PORT_CTRL_C_RESET;
        else if (wr_control) ctrl_c[p][C_CROSSOVER_VARIANT] <= wd[CTL_CROSSOVER_VARIANT];
        else if (sw_wr_c) ctrl_c[p] <= sw_wdata_in;
      end

      // diagnostic words, management path only
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          cable_diag[p] <= CABLE_DIAG_RESET;
          special[p] <= SPECIAL_RESET;
        end else begin
          if (wr_cable) cable_diag[p] <= wd;
          if (wr_special) special[p] <= wd;
        end
      end

      // fault flag registered so the output is a flop
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) far_fault_out[p] <= 1'b0;
        else far_fault_out[p] <= fault_seen;
      end

      // controls come straight off the stored bytes
      assign loopback_out[p] = ctrl_b[p][B_LOOPBACK];
      assign force_100_out[p] = ctrl_a[p][A_FORCE_100];
      assign an_enable_out[p] = ctrl_a[p][A_AN_ENABLE];
      assign full_duplex_out[p] = ctrl_a[p][A_FULL_DUPLEX];
      assign power_down_out[p] = ctrl_b[p][B_POWER_DOWN];
      assign restart_an_out[p] = ctrl_b[p][B_RESTART_AN];
      assign crossover_variant_select_out[p] = ctrl_c[p][C_CROSSOVER_VARIANT];
      assign force_straight_out[p] = ctrl_b[p][B_FORCE_STRAIGHT];
      assign crossover_disable_out[p] = ctrl_b[p][B_CROSSOVER_DISABLE];
      assign fault_detect_disable_out[p] = ctrl_b[p][B_FAULT_DISABLE];
      assign transmit_disable_out[p] = ctrl_b[p][B_TRANSMIT_DISABLE];
      assign indicator_disable_out[p] = ctrl_b[p][B_INDICATOR_DISABLE];
      assign sw_word_a[p] = ctrl_a[p];
      assign sw_word_b[p] = ctrl_b[p];
      assign sw_word_c[p] = ctrl_c[p];
    end
  endgenerate

  // switch-side read mux, unmapped bytes read zero
  wire logic [7:0] sw_read =
    (sw_addr_in == SW_GLOBAL_ADDRESS_OFFSET) ? global_addr :
    (sw_addr_in == SW_PORT_CTRL_A_OFFSET) ? sw_word_a[0] :
    (sw_addr_in == SW_PORT_CTRL_B_OFFSET) ? sw_word_b[0] :
    (sw_addr_in == SW_PORT_CTRL_C_OFFSET) ? sw_word_c[0] :
    (sw_addr_in == 8'(SW_PORT_CTRL_A_OFFSET + SW_PORT_STRIDE)) ? sw_word_a[1] :
    (sw_addr_in == 8'(SW_PORT_CTRL_B_OFFSET + SW_PORT_STRIDE)) ? sw_word_b[1] :
    (sw_addr_in == 8'(SW_PORT_CTRL_C_OFFSET + SW_PORT_STRIDE)) ? sw_word_c[1] : 8'h00;

  // registered so the byte port answer is one clock behind the address
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) sw_rdata_out <= 8'h00;
    else sw_rdata_out <= sw_read;
  end

endmodule // phy_mgmt_regs

//--- testbench/phy_mgmt_regs_properties.sv
`timescale 1ns/100ps
module phy_mgmt_regs_properties
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  // switch byte port
  input wire logic [7:0] sw_addr_in,
  input wire logic sw_wr_in,
  input wire logic [7:0] sw_wdata_in,
  input wire logic [7:0] sw_rdata_out,
  // fault path and controls
  input wire logic [1:0] far_fault_in,
  input wire logic [1:0] far_fault_out,
  input wire logic [1:0] loopback_out,
  input wire logic [1:0] an_enable_out,
  input wire logic [1:0] crossover_variant_select_out,
  input wire logic [1:0] force_straight_out,
  input wire logic [1:0] crossover_disable_out,
  input wire logic [1:0] fault_detect_disable_out
);
  logic mdc_seen;
  logic [5:0] since_rise;
  wire logic [5:0] next_since_rise;

  // clocks since the last management clock rise; saturates so it never wraps
  assign next_since_rise = (mdc_in && !mdc_seen) ? 6'h00 :
    (since_rise == 6'h3f) ? since_rise : since_rise + 6'h01;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mdc_seen <= 1'b0;
      since_rise <= 6'h3f;
    end else begin
      mdc_seen <= mdc_in;
      since_rise <= next_since_rise;
    end
  end

  default clocking dc @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence byte_write(logic [7:0] a);
    sw_wr_in && sw_addr_in == a;
  endsequence
  sequence fault_off_held;
    fault_detect_disable_out[0] ##1 fault_detect_disable_out[0];
  endsequence
  sequence fault_on_held;
    (!fault_detect_disable_out[0] && far_fault_in[0]) ##1 !fault_detect_disable_out[0];
  endsequence

  chk_reset_values: assert property ($fell(rst_in) |->
    an_enable_out == 2'b11 && crossover_variant_select_out == 2'b11 && loopback_out == 2'b00
    && force_straight_out == 2'b00 && crossover_disable_out == 2'b00
    && fault_detect_disable_out == 2'b00) else $error("control outputs wrong after reset");
  chk_loop_port1: assert property (byte_write(8'h1d) |=>
    loopback_out[0] == $past(sw_wdata_in[0])) else $error("port 1 loopback not aliased");
  chk_loop_port2: assert property (byte_write(8'h2d) |=>
    loopback_out[1] == $past(sw_wdata_in[0])) else $error("port 2 loopback not aliased");
  chk_crossover_bits: assert property (byte_write(8'h1d) |=>
    {fault_detect_disable_out[0], crossover_disable_out[0], force_straight_out[0]}
    == {$past(sw_wdata_in[4]), $past(sw_wdata_in[2:1])}) else $error("byte b bits not aliased");
  chk_variant_port2: assert property (byte_write(8'h2f) |=>
    crossover_variant_select_out[1] == $past(sw_wdata_in[7])) else $error("variant not aliased");
  chk_byte_readback: assert property (byte_write(8'h1d) ##1
    (!sw_wr_in && sw_addr_in == 8'h1d) |=> sw_rdata_out == $past(sw_wdata_in, 2))
    else $error("byte readback wrong");
  chk_fault_masked: assert property (fault_off_held |-> !far_fault_out[0])
    else $error("fault shown while disabled");
  chk_fault_passed: assert property (fault_on_held |-> far_fault_out[0])
    else $error("fault lost while enabled");
  chk_drive_timing: assert property ($rose(mdio_oe_out) |-> since_rise <= 6'h08)
    else $error("drive began away from a clock rise");
  chk_data_timing: assert property ($changed(mdio_out) && mdio_oe_out |->
    since_rise <= 6'h08) else $error("data moved away from a clock rise");
endmodule // phy_mgmt_regs_properties

bind phy_mgmt_regs phy_mgmt_regs_properties chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .mdc_in(mdc_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .sw_addr_in(sw_addr_in),
  .sw_wr_in(sw_wr_in), .sw_wdata_in(sw_wdata_in), .sw_rdata_out(sw_rdata_out),
  .far_fault_in(far_fault_in), .far_fault_out(far_fault_out), .loopback_out(loopback_out),
  .an_enable_out(an_enable_out), .crossover_variant_select_out(crossover_variant_select_out),
  .force_straight_out(force_straight_out), .crossover_disable_out(crossover_disable_out),
  .fault_detect_disable_out(fault_detect_disable_out));

//--- testbench/mdio_station.sv
`timescale 1ns/100ps
module mdio_station
  import phy_mgmt_pkg::*;
(
  // clock
  input wire logic clk_in,
  // device side of the data pin
  input wire logic dev_data_in,
  input wire logic dev_oe_in,
  // management pins
  output logic mdc_out,
  output logic mdio_out
);
  logic drive = 1'b0;
  logic level = 1'b1;

  // shared pin with a pull-up: released means high, never the last value
  assign mdio_out = dev_oe_in ? dev_data_in : (drive ? level : 1'b1);
  initial mdc_out = 1'b0;

  // one whole frame at a 40 ns management clock, which stands still between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] idx,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, idx, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      mdc_out = 1'b0;
      drive = !(op == OP_READ && i >= 46);
      level = bits[63 - i];
      repeat (5) @(posedge clk_in);
      #1;
      if (i >= 48) rd = {rd[14:0], mdio_out};
      mdc_out = 1'b1;
      repeat (5) @(posedge clk_in);
      #1;
    end
    mdc_out = 1'b0;
    drive = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
  endtask
endmodule // mdio_station

//--- testbench/phy_mgmt_register_map_bench.sv
`timescale 1ns/100ps
`define CHECK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL %s expected %h seen %h", name, exp, got); end end
module phy_management_register_map_bench
  import phy_mgmt_pkg::*;
;
  localparam logic [15:0] ID_HIGH = 16'h0abc; // arbitrary value
  localparam logic [15:0] ID_LOW = 16'h0def; // arbitrary value
  typedef struct packed {
    logic [4:0] phy;
    logic [4:0] idx;
    logic [15:0] wd;
    logic [15:0] exp;
  } row_type;
  // each row: write the word, then read it back
  localparam row_type ROWS [17] = '{
    '{5'h01, 5'h00, 16'hffff, 16'h7b3f},
    '{5'h01, 5'h00, 16'h1020, 16'h1020},
    '{5'h02, 5'h00, 16'h4000, 16'h4000},
    '{5'h02, 5'h00, 16'h1020, 16'h1020},
    '{5'h02, 5'h1d, 16'ha5c3, 16'ha5c3},
    '{5'h01, 5'h1f, 16'h3c5a, 16'h3c5a},
    '{5'h01, 5'h06, 16'hffff, 16'h0000},
    '{5'h02, 5'h1c, 16'hffff, 16'h0000},
    '{5'h01, 5'h1e, 16'hffff, 16'h0000},
    '{5'h01, 5'h02, 16'hffff, ID_HIGH},
    '{5'h02, 5'h03, 16'hffff, ID_LOW},
    '{5'h01, 5'h01, 16'hffff, 16'h782c},
    '{5'h02, 5'h01, 16'hffff, 16'h7808},
    '{5'h01, 5'h05, 16'hffff, 16'h04a0},
    '{5'h02, 5'h04, 16'h0000, 16'h0001},
    '{5'h02, 5'h04, 16'hffff, 16'h05e1},
    '{5'h03, 5'h00, 16'h0000, 16'hffff}
  };
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sw_wr = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic [1:0] far_fault = 2'b00;
  logic [1:0][4:0] ability = {5'h0a, 5'h15};
  wire logic mdc, mdio, dev_data, dev_oe;
  logic [7:0] sw_rdata_out, bd;
  logic [15:0] rd;
  logic [1:0] loopback_out, an_enable_out, crossover_variant_select_out, far_fault_out;
  logic [1:0] force_straight_out, crossover_disable_out, fault_detect_disable_out;
  logic [1:0] force_100_out, full_duplex_out, power_down_out, restart_an_out;
  logic [1:0] transmit_disable_out, indicator_disable_out;
  // the six plain line options, two bits each, port 2 in the upper bit
  wire logic [11:0] line_opts = {force_100_out, full_duplex_out, power_down_out,
    restart_an_out, transmit_disable_out, indicator_disable_out};
  int errors = 0;
  int n_tests = 0;

  always #2 clk_in = ~clk_in;

  phy_mgmt_regs #(.IDENTIFIER_HIGH(ID_HIGH), .IDENTIFIER_LOW(ID_LOW)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .mdc_in(mdc), .mdio_in(mdio), .mdio_out(dev_data),
    .mdio_oe_out(dev_oe), .sw_addr_in(sw_addr), .sw_wr_in(sw_wr), .sw_wdata_in(sw_wdata),
    .sw_rdata_out(sw_rdata_out), .link_up_in(2'b01), .an_done_in(2'b01),
    .far_fault_in(far_fault), .partner_ability_in(ability), .loopback_out(loopback_out),
    .force_100_out(force_100_out), .an_enable_out(an_enable_out),
    .power_down_out(power_down_out), .restart_an_out(restart_an_out),
    .full_duplex_out(full_duplex_out),
    .crossover_variant_select_out(crossover_variant_select_out),
    .force_straight_out(force_straight_out), .crossover_disable_out(crossover_disable_out),
    .fault_detect_disable_out(fault_detect_disable_out),
    .transmit_disable_out(transmit_disable_out),
    .indicator_disable_out(indicator_disable_out), .far_fault_out(far_fault_out));

  mdio_station mgr_u (.clk_in(clk_in), .dev_data_in(dev_data), .dev_oe_in(dev_oe),
    .mdc_out(mdc), .mdio_out(mdio));

  task automatic close_out();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // byte port: one-cycle strobe, then a quiet cycle so strobes never merge
  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    sw_addr = a;
    sw_wdata = d;
    sw_wr = 1'b1;
    @(posedge clk_in);
    #1;
    sw_wr = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic brd(input logic [7:0] a, output logic [7:0] d);
    sw_addr = a;
    repeat (2) @(posedge clk_in);
    #1;
    d = sw_rdata_out;
  endtask
  task automatic mrd(input logic [4:0] phy, input logic [4:0] idx, output logic [15:0] d);
    mgr_u.frame(OP_READ, phy, idx, 16'h0000, d);
  endtask
  task automatic reset_dut();
    rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
  endtask

  // watchdog so a hang still reaches the verdict
  initial begin
    repeat (90000) @(posedge clk_in);
    errors++;
    $display("FAIL watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    reset_dut();
    foreach (ROWS[i]) begin
      mgr_u.frame(OP_WRITE, ROWS[i].phy, ROWS[i].idx, ROWS[i].wd, rd);
      mrd(ROWS[i].phy, ROWS[i].idx, rd);
      `CHECK("mgmt row", ROWS[i].exp, rd)
    end
    // byte-side writes must show in the control word and the outputs
    bwr(8'h1d, 8'h17);
    `CHECK("loop p1", 2'b01, loopback_out)
    `CHECK("straight", 2'b01, force_straight_out)
    `CHECK("xover off", 2'b01, crossover_disable_out)
    mrd(5'h01, 5'h00, rd);
    `CHECK("ctrl p1", 16'h503c, rd)
    bwr(8'h2d, 8'hf9);
    bwr(8'h2c, 8'he0);
    bwr(8'h2f, 8'h00);
    `CHECK("loop p2", 2'b11, loopback_out)
    `CHECK("variant", 2'b01, crossover_variant_select_out)
    `CHECK("p2 line opts", 12'haaa, line_opts)
    mrd(5'h02, 5'h00, rd);
    `CHECK("ctrl p2", 16'h7b07, rd)
    // fault masking both ways, then management clears byte-side bits
    far_fault = 2'b11;
    repeat (3) @(posedge clk_in);
    #1;
    `CHECK("fault masked", 2'b00, far_fault_out)
    mgr_u.frame(OP_WRITE, 5'h01, 5'h00, 16'h0000, rd);
    `CHECK("fault shown", 2'b01, far_fault_out)
    `CHECK("an enable", 2'b10, an_enable_out)
    brd(8'h1d, bd);
    `CHECK("byte b", 8'h00, bd)
    brd(8'h1c, bd);
    `CHECK("byte a", 8'h1f, bd)
    mrd(5'h01, 5'h01, rd);
    `CHECK("status fault", 16'h783c, rd)
    bwr(8'h1e, 8'hff);
    brd(8'h1e, bd);
    `CHECK("unmapped byte", 8'h00, bd)
    // moved transceiver addresses; the old one goes silent
    bwr(8'h0f, 8'h28);
    mrd(5'h05, 5'h02, rd);
    `CHECK("moved p1", ID_HIGH, rd)
    mrd(5'h06, 5'h03, rd);
    `CHECK("moved p2", ID_LOW, rd)
    mrd(5'h01, 5'h02, rd);
    `CHECK("old p1", 16'hffff, rd)
    // second reset in mid-run restores every default
    reset_dut();
    `CHECK("reset an", 2'b11, an_enable_out)
    `CHECK("reset variant", 2'b11, crossover_variant_select_out)
    `CHECK("reset fault off", 2'b00, fault_detect_disable_out)
    `CHECK("reset line opts", 12'h000, line_opts)
    brd(8'h0f, bd);
    `CHECK("reset global", 8'h08, bd)
    mrd(5'h01, 5'h00, rd);
    `CHECK("reset ctrl", 16'h1020, rd)
    close_out();
  end
endmodule // phy_management_register_map_bench
